// *** shared/pcd_pkg.sv ***
// Purpose: Shared constants for the pin change detect block.
// Assumes: AHB-Lite register access with 32-bit aligned words.
// Notes:   Port index order is A, B, C, E.
package pcd_pkg;
  localparam int NUM_PORTS = 4;
  localparam int PORT_W    = 8;
  localparam int ADDR_W    = 8;

  // Per-port register sets; port p sits at base plus p times stride.
  localparam logic [7:0] RISE_BASE   = 8'h00;
  localparam logic [7:0] FALL_BASE   = 8'h10;
  localparam logic [7:0] FLAGS_BASE  = 8'h20;
  localparam logic [7:0] PORT_STRIDE = 8'h04;
  localparam logic [7:0] CTRL_ADDR   = 8'h30;
  localparam logic [7:0] STATUS_ADDR = 8'h34;
  localparam logic [7:0] IRQ_EN_ADDR = 8'h38;
  localparam logic [7:0] IRQ_CLR_ADDR = 8'h3C;

  // Implemented bits per port: A, B, C full, E only bit 3.
  localparam logic [7:0] PORT_MASK [NUM_PORTS] = '{8'hFF, 8'hFF, 8'hFF, 8'h08};

  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam int CTRL_MASTER_BIT    = 0;
  localparam int CTRL_SLEEP_BIT     = 1;
  localparam int STATUS_SUMMARY_BIT = 0;
  localparam int EVT_EDGE_BIT       = 0;
  localparam int EVT_WAKE_BIT       = 1;
  localparam int EVT_W              = 2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage

// *** logic/pcd_sync_edge.sv ***
// Purpose: Two-flop synchroniser and edge detector for a group of pins.
// Assumes: Pins are asynchronous to hclk.
// Notes:   The first flop feeds only the second one.
module pcd_sync_edge #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Pins and edges
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] rise_pulse,
  output logic      [WIDTH-1:0] fall_pulse
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edges compare the settled sample with the one before it.
  assign rise_pulse = sync_reg & ~prev_reg;
  assign fall_pulse = ~sync_reg & prev_reg;
endmodule

// *** logic/pcd_port_flags.sv ***
// Purpose: Edge enables and sticky flags for one port.
// Assumes: Writes arrive as one-cycle strobes with data.
// Notes:   Unimplemented bits are held at zero by the mask.
module pcd_port_flags #(
  parameter logic [7:0] MASK = 8'hFF
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Edges
  input  wire logic [7:0] rise_pulse,
  input  wire logic [7:0] fall_pulse,
  // Register writes
  input  wire logic [7:0] wdata,
  input  wire logic       rise_we,
  input  wire logic       fall_we,
  input  wire logic       flags_we,
  // Register state
  output logic      [7:0] rise_en_reg,
  output logic      [7:0] fall_en_reg,
  output logic      [7:0] flags_reg
);
  logic [7:0] hit;
  logic [7:0] flags_next;

  // Each edge is qualified by its own enable; both may be set.
  assign hit = ((rise_pulse & rise_en_reg) | (fall_pulse & fall_en_reg)) & MASK;
  // Writing zero clears, but a same-cycle edge keeps the flag.
  assign flags_next = (flags_we ? (wdata & MASK) : flags_reg) | hit;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_en_reg <= pcd_pkg::REG_RESET;
      fall_en_reg <= pcd_pkg::REG_RESET;
      flags_reg   <= pcd_pkg::REG_RESET;
    end else begin
      if (rise_we) rise_en_reg <= wdata & MASK;
      if (fall_we) fall_en_reg <= wdata & MASK;
      flags_reg <= flags_next;
    end
  end
endmodule

// *** logic/pcd_top.sv ***
// Purpose: Pin change detect interrupt unit with an AHB-Lite register slave.
// Assumes: hclk at 20 MHz; pins asynchronous; single word transfers.
// Notes:   Register reads answer with zero wait states and OKAY.
// Functional notes
// - Every pin of ports A, B and C, and pin 3 of port E, can be enabled on its own to raise the change interrupt.
// - With the master enable clear, flags still set but change_irq is not raised; block_irq still follows status and its enable.
// - A rising edge is seen only when the pin's rise enable bit is one.
// - A falling edge is seen only when the pin's fall enable bit is one.
// - With both enables set, either edge flags the pin.
// - An enabled edge sets the pin flag and interrupts when the master enable is set.
// - The summary flag is one while any pin flag is set, and is read only.
// - Writing zero to a flag bit clears it.
// - An edge in the same cycle as a flag write leaves that flag set.
// - A change event wakes the device from sleep when the master enable is set.
// - An edge during sleep sets its flag before the core resumes.
// - Edge enable registers are eight bits, read and write, zero after reset.
// - Flags are read and write, set by hardware, zero after reset.
// - Port E implements only bit 3 in its three registers; others read zero.
// - Register sets exist for ports A, B, C and E.
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
module pcd_top (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Port pins A, B, C, E
  input  wire logic [7:0]  pin_a,
  input  wire logic [7:0]  pin_b,
  input  wire logic [7:0]  pin_c,
  input  wire logic [7:0]  pin_e,
  // Core side
  output logic             change_irq,
  output logic             wake_req,
  output logic             change_irq_summary_flag,
  output logic             block_irq
);
  localparam int NP = pcd_pkg::NUM_PORTS;

  logic [7:0] pins   [NP];
  logic [7:0] rise_p [NP];
  logic [7:0] fall_p [NP];
  logic [7:0] rise_en[NP];
  logic [7:0] fall_en[NP];
  logic [7:0] flags  [NP];
  logic [NP-1:0] rise_we;
  logic [NP-1:0] fall_we;
  logic [NP-1:0] flags_we;

  assign pins[0] = pin_a;
  assign pins[1] = pin_b;
  assign pins[2] = pin_c;
  assign pins[3] = pin_e;

  // Bus address phase capture.
  logic       wr_pend_reg;
  logic [7:0] waddr_reg;
  logic       master_en_reg;
  logic       sleep_reg;
  logic [pcd_pkg::EVT_W-1:0] irq_status_reg;
  logic [pcd_pkg::EVT_W-1:0] irq_status_next;
  logic [pcd_pkg::EVT_W-1:0] irq_en_reg;
  logic [31:0] rdata_next;
  logic [7:0]  wbyte;
  logic        addr_phase;
  logic        any_flag;
  logic        any_hit;
  logic        wake_evt;
  logic        ctrl_we;
  logic        irq_en_we;
  logic        irq_clr_we;
  logic [7:0]  raddr;

  assign addr_phase = hsel & hready & (htrans == pcd_pkg::HTRANS_NONSEQ ||
                                       htrans == pcd_pkg::HTRANS_SEQ);
  assign raddr = haddr[7:0];
  assign wbyte = hwdata[7:0];

  function automatic logic [7:0] port_addr(input logic [7:0] base, input int p);
    port_addr = base + 8'(p) * pcd_pkg::PORT_STRIDE;
  endfunction

  function automatic logic hit_addr(input logic [7:0] a, input logic [7:0] target);
    hit_addr = (a == target);
  endfunction

  // Every port gets a synchroniser and its own flag set.
  for (genvar p = 0; p < NP; p++) begin : g_port
    pcd_sync_edge #(.WIDTH(pcd_pkg::PORT_W)) u_sync (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .pin_in     (pins[p]),
      .rise_pulse (rise_p[p]),
      .fall_pulse (fall_p[p])
    );
    assign rise_we[p]  = wr_pend_reg & hit_addr(waddr_reg, port_addr(pcd_pkg::RISE_BASE, p));
    assign fall_we[p]  = wr_pend_reg & hit_addr(waddr_reg, port_addr(pcd_pkg::FALL_BASE, p));
    assign flags_we[p] = wr_pend_reg & hit_addr(waddr_reg, port_addr(pcd_pkg::FLAGS_BASE, p));
    pcd_port_flags #(.MASK(pcd_pkg::PORT_MASK[p])) u_flags (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .rise_pulse  (rise_p[p]),
      .fall_pulse  (fall_p[p]),
      .wdata       (wbyte),
      .rise_we     (rise_we[p]),
      .fall_we     (fall_we[p]),
      .flags_we    (flags_we[p]),
      .rise_en_reg (rise_en[p]),
      .fall_en_reg (fall_en[p]),
      .flags_reg   (flags[p])
    );
  end

  // Summary is a live OR of all flags, never stored.
  always_comb begin
    any_flag = 1'b0;
    any_hit  = 1'b0;
    for (int p = 0; p < NP; p++) begin
      any_flag = any_flag | (|flags[p]);
      any_hit  = any_hit | (|(((rise_p[p] & rise_en[p]) | (fall_p[p] & fall_en[p]))
                               & pcd_pkg::PORT_MASK[p]));
    end
  end
  assign change_irq_summary_flag = any_flag;

  // Master enable gates only the request, not the flags.
  assign change_irq = master_en_reg & any_flag;
  // Flags update in the edge cycle, so they are set before wake is seen.
  assign wake_req = sleep_reg & master_en_reg & any_flag;
  assign wake_evt = wake_req;

  assign ctrl_we    = wr_pend_reg & hit_addr(waddr_reg, pcd_pkg::CTRL_ADDR);
  assign irq_en_we  = wr_pend_reg & hit_addr(waddr_reg, pcd_pkg::IRQ_EN_ADDR);
  assign irq_clr_we = wr_pend_reg & hit_addr(waddr_reg, pcd_pkg::IRQ_CLR_ADDR);

  // Set beats clear, so an event in the clear cycle survives.
  always_comb begin
    irq_status_next = irq_status_reg;
    if (irq_clr_we) begin
      irq_status_next = irq_status_reg & ~hwdata[pcd_pkg::EVT_W-1:0];
    end
    if (any_hit) begin
      irq_status_next[pcd_pkg::EVT_EDGE_BIT] = 1'b1;
    end
    if (wake_evt) begin
      irq_status_next[pcd_pkg::EVT_WAKE_BIT] = 1'b1;
    end
  end
  assign block_irq = |(irq_status_reg & irq_en_reg);

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rdata_next = '0;
    for (int p = 0; p < NP; p++) begin
      if (hit_addr(raddr, port_addr(pcd_pkg::RISE_BASE, p)))  rdata_next[7:0] = rise_en[p];
      if (hit_addr(raddr, port_addr(pcd_pkg::FALL_BASE, p)))  rdata_next[7:0] = fall_en[p];
      if (hit_addr(raddr, port_addr(pcd_pkg::FLAGS_BASE, p))) rdata_next[7:0] = flags[p];
    end
    if (hit_addr(raddr, pcd_pkg::CTRL_ADDR)) begin
      rdata_next[pcd_pkg::CTRL_MASTER_BIT] = master_en_reg;
      rdata_next[pcd_pkg::CTRL_SLEEP_BIT]  = sleep_reg;
    end
    if (hit_addr(raddr, pcd_pkg::STATUS_ADDR)) begin
      rdata_next[pcd_pkg::EVT_W-1:0] = irq_status_reg;
    end
    if (hit_addr(raddr, pcd_pkg::IRQ_EN_ADDR)) begin
      rdata_next[pcd_pkg::EVT_W-1:0] = irq_en_reg;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      waddr_reg   <= '0;
      hrdata      <= '0;
    end else begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase) waddr_reg <= raddr;
      if (addr_phase & ~hwrite) hrdata <= rdata_next;
    end
  end

  // Sleep clears itself on wake so the core resumes once.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      master_en_reg  <= 1'b0;
      sleep_reg      <= 1'b0;
      irq_status_reg <= '0;
      irq_en_reg     <= '0;
    end else begin
      irq_status_reg <= irq_status_next;
      if (irq_en_we) irq_en_reg <= hwdata[pcd_pkg::EVT_W-1:0];
      if (ctrl_we) begin
        master_en_reg <= hwdata[pcd_pkg::CTRL_MASTER_BIT];
        sleep_reg     <= hwdata[pcd_pkg::CTRL_SLEEP_BIT];
      end else if (wake_evt) begin
        sleep_reg <= 1'b0;
      end
    end
  end
endmodule

// *** sim/pcd_top_assertions.sv ***
// Purpose: Port-level checks of the pin change detect block.
// Assumes: A register changes only at the edge that ends a write data phase.
// Notes:   Port E bits other than bit 3 are masked, since their edges never reach a flag.
module pcd_checker (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Bus
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hreadyout,
  input wire logic       hresp,
  // Pins
  input wire logic [7:0] pin_a,
  input wire logic [7:0] pin_b,
  input wire logic [7:0] pin_c,
  input wire logic [7:0] pin_e,
  // Core side
  input wire logic       change_irq,
  input wire logic       wake_req,
  input wire logic       change_irq_summary_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] pins_reg;
  logic [3:0]  quiet_reg;
  wire logic        wr_addr  = hsel && hwrite && htrans[1];
  wire logic [31:0] pins_now = {pin_e & 8'h08, pin_c, pin_b, pin_a};
  // Counts cycles since any live pin moved, so late flag rises can be blamed on writes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_reg  <= 32'h0;
      quiet_reg <= 4'h0;
    end else begin
      pins_reg  <= pins_now;
      quiet_reg <= (pins_now != pins_reg) ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hF};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  irq_gate_a: assert property (change_irq |-> change_irq_summary_flag)
    else $error("change_irq high with no flag set");
  wake_gate_a: assert property (wake_req |-> change_irq)
    else $error("wake_req without an enabled change request");
  // A write lands one edge after its address phase is taken, so blame looks two edges back.
  flag_clear_a: assert property ($fell(change_irq_summary_flag) |-> $past(wr_addr, 2))
    else $error("flags cleared without a write");
  flag_sticky_a: assert property (change_irq_summary_flag && !$past(wr_addr)
                                  |=> change_irq_summary_flag)
    else $error("flag dropped on its own");
  irq_hold_a: assert property (change_irq && !$past(wr_addr) |=> change_irq)
    else $error("change_irq dropped without a write");
  quiet_set_a: assert property ($rose(change_irq_summary_flag) && quiet_reg > 4'h8
                                |-> $past(wr_addr, 2))
    else $error("flag set with pins quiet");
  reset_clean_a: assert property ($rose(hresetn) |-> !change_irq_summary_flag && !wake_req)
    else $error("flags not clear after reset");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not OKAY");
endmodule
bind pcd_top pcd_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .pin_a(pin_a), .pin_b(pin_b),
  .pin_c(pin_c), .pin_e(pin_e), .change_irq(change_irq), .wake_req(wake_req),
  .change_irq_summary_flag(change_irq_summary_flag));

// *** sim/pcd_pin_model.sv ***
// Purpose: Far side: port pins and the core's interrupt input.
// Assumes: The bench gives pin levels as one word, port A in the low byte.
// Notes:   Pins move 7 ns after the edge, so they are not aligned to hclk.
module pcd_pin_model (
  // Clock and control
  input  wire logic        hclk,
  input  wire logic [31:0] level,
  // Pins
  output logic      [7:0]  pin_a,
  output logic      [7:0]  pin_b,
  output logic      [7:0]  pin_c,
  output logic      [7:0]  pin_e,
  // Core side
  input  wire logic        change_irq,
  output logic             irq_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] junk = 8'h00;
  // Unbonded port E pins toggle every cycle; none may ever reach a flag.
  always @(posedge hclk) junk <= ~junk;
  always @(posedge hclk) irq_seen <= change_irq;
  assign #7 pin_a = level[7:0];
  assign #7 pin_b = level[15:8];
  assign #7 pin_c = level[23:16];
  assign #7 pin_e = (level[31:24] & 8'h08) | (junk & 8'hF7);
endmodule

// *** sim/pcd_top_tb_top.sv ***
// Purpose: Self-checking bench for the pin change detect block.
// Assumes: Zero-wait slave; a pin move reaches its flag within six cycles.
// Notes:   Port order in tables is A, B, C, E.
module pcd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, wake, summ, blk, seen, woke;
  logic [31:0] haddr, hwdata, hrdata, lvl, rd;
  logic [1:0]  htrans;
  logic [7:0]  pa, pb, pc, pe;
  int          fail_count, n_tests, i;
  localparam logic [7:0] BASES [3] = '{pcd_pkg::RISE_BASE, pcd_pkg::FALL_BASE, 8'h20};
  localparam logic [7:0] EN [8] = '{8'h05, 8'hFF, 8'h00, 8'hFF, 8'h06, 8'h00, 8'h80, 8'h00};
  pcd_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pin_a(pa), .pin_b(pb), .pin_c(pc), .pin_e(pe),
    .change_irq(irq), .wake_req(wake), .change_irq_summary_flag(summ), .block_irq(blk));
  pcd_pin_model u_pins (.hclk(hclk), .level(lvl), .pin_a(pa), .pin_b(pb), .pin_c(pc),
    .pin_e(pe), .change_irq(irq), .irq_seen(seen));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= pcd_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("Error value at %h expected %h seen %h", haddr[7:0], e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk(e, rd);
  endtask
  task automatic pins(input logic [31:0] v);
    lvl <= v;
    repeat (6) @(posedge hclk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    hclk = 1'h0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    #(3000 * 50);
    fail_count++;
    report_and_stop;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, lvl, fail_count, n_tests, woke} = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    for (i = 0; i < 12; i++) rchk(BASES[i/4] + 8'(4 * (i % 4)), 32'h0);
    for (i = 0; i < 8; i++) begin
      xfer(1'h1, BASES[i/4] + 8'(4 * (i % 4)), 32'hFFFF_FFFF);
      rchk(BASES[i/4] + 8'(4 * (i % 4)), {24'h0, pcd_pkg::PORT_MASK[i%4]});
      xfer(1'h1, BASES[i/4] + 8'(4 * (i % 4)), {24'h0, EN[i]});
    end
    rchk(8'h40, 32'h0);
    pins(32'hFFFF_FFFF);
    chk(32'h1, {irq, summ});
    for (i = 0; i < 4; i++) rchk(8'(8'h20 + 4 * i), {24'h0, EN[i] & pcd_pkg::PORT_MASK[i]});
    pins(32'h0);
    rchk(8'h20, 32'h07);
    rchk(8'h28, 32'h80);
    for (i = 0; i < 4; i++) xfer(1'h1, 8'(8'h20 + 4 * i), 32'h0);
    // The last clear lands at the edge the task returns on; let it settle first.
    @(posedge hclk);
    chk(32'h0, {31'h0, summ});
    xfer(1'h1, pcd_pkg::CTRL_ADDR, 32'h1);
    xfer(1'h1, pcd_pkg::IRQ_EN_ADDR, 32'h1);
    pins(32'h0000_0100);
    chk(32'h7, {29'h0, irq, blk, seen});
    rchk(pcd_pkg::STATUS_ADDR, 32'h1);
    xfer(1'h1, pcd_pkg::IRQ_EN_ADDR, 32'h0);
    @(posedge hclk);
    chk(32'h0, {31'h0, blk});
    xfer(1'h1, pcd_pkg::IRQ_CLR_ADDR, 32'h3);
    rchk(pcd_pkg::STATUS_ADDR, 32'h0);
    xfer(1'h1, 8'h24, 32'h0);
    @(posedge hclk);
    chk(32'h0, {31'h0, irq});
    xfer(1'h1, pcd_pkg::CTRL_ADDR, 32'h3);
    pins(32'h0080_0100);
    lvl <= 32'h0000_0100;
    for (i = 0; i < 20 && !woke; i++) @(posedge hclk) woke = (wake === 1'h1);
    chk(32'h1, {31'h0, woke});
    rchk(8'h28, 32'h80);
    rchk(pcd_pkg::CTRL_ADDR, 32'h1);
    rchk(pcd_pkg::STATUS_ADDR, 32'h3);
    // Pin A0 rises so that its edge reaches the flag in the very cycle the clear lands.
    lvl <= 32'h0000_0101;
    @(posedge hclk);
    xfer(1'h1, 8'h20, 32'h0);
    rchk(8'h20, 32'h01);
    report_and_stop;
  end
endmodule
